// ### hw/pwm_channel_ctl.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_ctl (
  // clock and reset
  input  wire logic                             I_CLK,
  input  wire logic                             I_RST,
  // apb slave
  input  wire logic                             I_PSEL,
  input  wire logic                             I_PENABLE,
  input  wire logic                             I_PWRITE,
  input  wire logic [7:0]                       I_PADDR,
  input  wire logic [31:0]                      I_PWDATA,
  output logic      [31:0]                      O_PRDATA,
  output logic                                  O_PREADY,
  output logic                                  O_PSLVERR,
  // per-channel period and duty
  input  wire pwm_ctl_pkg::ch_cfg_s [5:0]       I_CH_CFG,
  // channel outputs and prescaler run flag
  output logic      [5:0]                       O_PWM,
  output logic      [5:0]                       O_PWM_OE_N,
  output logic                                  O_PRESCALE_RUN
);
  import pwm_ctl_pkg::*;

  //==========================================================
  // helpers
  function automatic logic reg_mapped(input logic [5:0] idx);
    reg_mapped = (idx == IDX_ENABLE) || (idx == IDX_POLARITY) ||
                 (idx == IDX_CLKSEL) || (idx == IDX_PRESCALE) ||
                 (idx == IDX_CONCAT) || (idx == IDX_SCALE_A) ||
                 (idx == IDX_SCALE_B);
  endfunction

  // divide by two to the power sel
  function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    div_tick = (cnt & mask) == mask;
  endfunction

  // scaled clock: one tick per 2*scale input ticks, scale zero means 256
  function automatic logic scale_last(input logic [8:0] cnt, input logic [7:0] scale);
    logic [9:0] lim;
    lim = (scale == 8'h00) ? 10'h1FF : 10'({scale, 1'b0} - 9'h001);
    scale_last = {1'b0, cnt} >= lim;
  endfunction

  function automatic logic [15:0] next_count(input logic [15:0] c, input logic [15:0] per);
    if (per == 16'h0000 || c >= per - 16'h0001) begin
      next_count = 16'h0000;
    end else begin
      next_count = c + 16'h0001;
    end
  endfunction

  function automatic logic wave_level(input logic pol, input logic [15:0] c,
                                      input logic [15:0] duty);
    wave_level = pol ? (c < duty) : (c >= duty);
  endfunction

  //==========================================================
  // register file
  logic [5:0]  en_q;
  logic [5:0]  en_d;
  logic [5:0]  pol_q;
  logic [5:0]  pol_d;
  logic [5:0]  clksel_q;
  logic [5:0]  clksel_d;
  logic [5:0]  prescale_q;
  logic [5:0]  prescale_d;
  logic [2:0]  concat_q;
  logic [2:0]  concat_d;
  logic [7:0]  scale_a_q;
  logic [7:0]  scale_a_d;
  logic [7:0]  scale_b_q;
  logic [7:0]  scale_b_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [5:0]  idx;
  logic        addr_ok;
  logic        wr;
  logic [7:0]  wbyte;
  logic [7:0]  rd_val;

  always_comb begin
    idx        = I_PADDR[7:2];
    addr_ok    = (I_PADDR[1:0] == 2'b00) && reg_mapped(idx);
    wr         = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
    wbyte      = I_PWDATA[7:0];
    en_d       = en_q;
    pol_d      = pol_q;
    clksel_d   = clksel_q;
    prescale_d = prescale_q;
    concat_d   = concat_q;
    scale_a_d  = scale_a_q;
    scale_b_d  = scale_b_q;
    rd_val     = 8'h00;
    // no access restriction on any register
    case (idx)
      IDX_ENABLE: begin
        rd_val = {2'b00, en_q};
        if (wr) begin
          en_d = wbyte[5:0];
        end
      end
      IDX_POLARITY: begin
        rd_val = {2'b00, pol_q};
        if (wr) begin
          pol_d = wbyte[5:0];
        end
      end
      IDX_CLKSEL: begin
        rd_val = {2'b00, clksel_q};
        if (wr) begin
          clksel_d = wbyte[5:0];
        end
      end
      IDX_PRESCALE: begin
        rd_val = {1'b0, prescale_q[5:3], 1'b0, prescale_q[2:0]};
        if (wr) begin
          prescale_d = {wbyte[PRE_B_LSB+2:PRE_B_LSB], wbyte[PRE_A_LSB+2:PRE_A_LSB]};
        end
      end
      IDX_CONCAT: begin
        rd_val = {1'b0, concat_q, 4'h0};
        if (wr) begin
          concat_d = wbyte[CONCAT_LSB+2:CONCAT_LSB];
        end
      end
      IDX_SCALE_A: begin
        rd_val = scale_a_q;
        if (wr) begin
          scale_a_d = wbyte;
        end
      end
      IDX_SCALE_B: begin
        rd_val = scale_b_q;
        if (wr) begin
          scale_b_d = wbyte;
        end
      end
      default: rd_val = 8'h00;
    endcase
    // read data captured in the setup cycle
    prdata_d = prdata_q;
    if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      prdata_d = addr_ok ? {24'h0000_00, rd_val} : 32'h0000_0000;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      en_q       <= RST_ENABLE;
      pol_q      <= RST_POLARITY;
      clksel_q   <= RST_CLKSEL;
      prescale_q <= RST_PRESCALE;
      concat_q   <= RST_CONCAT;
      scale_a_q  <= RST_SCALE;
      scale_b_q  <= RST_SCALE;
      prdata_q   <= 32'h0000_0000;
    end else begin
      en_q       <= en_d;
      pol_q      <= pol_d;
      clksel_q   <= clksel_d;
      prescale_q <= prescale_d;
      concat_q   <= concat_d;
      scale_a_q  <= scale_a_d;
      scale_b_q  <= scale_b_d;
      prdata_q   <= prdata_d;
    end
  end

  assign O_PRDATA  = prdata_q;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  //==========================================================
  // prescaler and scaled clocks
  logic [6:0] pre_cnt_q;
  logic [6:0] pre_cnt_d;
  logic [8:0] scaled_a_cnt_q;
  logic [8:0] scaled_a_cnt_d;
  logic [8:0] scaled_b_cnt_q;
  logic [8:0] scaled_b_cnt_d;
  logic       any_en;
  logic       a_tick;
  logic       b_tick;
  logic       scaled_a_tick;
  logic       scaled_b_tick;

  always_comb begin
    any_en         = |en_q;
    // counter frozen at zero while every enable bit is clear
    pre_cnt_d      = any_en ? 7'(pre_cnt_q + 7'h01) : 7'h00;
    a_tick         = any_en && div_tick(pre_cnt_q, prescale_q[2:0]);
    b_tick         = any_en && div_tick(pre_cnt_q, prescale_q[5:3]);
    scaled_a_tick  = a_tick && scale_last(scaled_a_cnt_q, scale_a_q);
    scaled_b_tick  = b_tick && scale_last(scaled_b_cnt_q, scale_b_q);
    scaled_a_cnt_d = scaled_a_cnt_q;
    scaled_b_cnt_d = scaled_b_cnt_q;
    if (!any_en) begin
      scaled_a_cnt_d = 9'h000;
    end else if (a_tick) begin
      scaled_a_cnt_d = scaled_a_tick ? 9'h000 : 9'(scaled_a_cnt_q + 9'h001);
    end
    if (!any_en) begin
      scaled_b_cnt_d = 9'h000;
    end else if (b_tick) begin
      scaled_b_cnt_d = scaled_b_tick ? 9'h000 : 9'(scaled_b_cnt_q + 9'h001);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pre_cnt_q      <= 7'h00;
      scaled_a_cnt_q <= 9'h000;
      scaled_b_cnt_q <= 9'h000;
    end else begin
      pre_cnt_q      <= pre_cnt_d;
      scaled_a_cnt_q <= scaled_a_cnt_d;
      scaled_b_cnt_q <= scaled_b_cnt_d;
    end
  end

  assign O_PRESCALE_RUN = any_en;

  //==========================================================
  // channels
  phase_e      phase_q [NUM_CH];
  phase_e      phase_d [NUM_CH];
  logic [7:0]  cnt_q   [NUM_CH];
  logic [7:0]  cnt_d   [NUM_CH];
  logic [5:0]  pwm_q;
  logic [5:0]  pwm_d;
  logic [5:0]  oe_n_q;
  logic [5:0]  oe_n_d;
  logic [5:0]  tick;
  logic [5:0]  en_eff;
  logic [15:0] c16;
  logic [15:0] per16;
  logic [15:0] duty16;
  int          lo;
  int          hi;

  always_comb begin
    c16    = 16'h0000;
    per16  = 16'h0000;
    duty16 = 16'h0000;
    lo     = 0;
    hi     = 0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (CLK_B_CH_MASK[ch]) begin
        tick[ch] = clksel_q[ch] ? scaled_b_tick : b_tick;
      end else begin
        tick[ch] = clksel_q[ch] ? scaled_a_tick : a_tick;
      end
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      hi = 2 * p;
      lo = 2 * p + 1;
      en_eff[lo] = en_q[lo];
      en_eff[hi] = en_q[hi] && !concat_q[p];
    end
    for (int ch = 0; ch < NUM_CH; ch++) begin
      // enable takes effect now, waveform waits for the next tick
      case (phase_q[ch])
        PH_IDLE: phase_d[ch] = en_eff[ch] ? PH_SYNC : PH_IDLE;
        PH_SYNC: phase_d[ch] = !en_eff[ch] ? PH_IDLE : (tick[ch] ? PH_RUN : PH_SYNC);
        PH_RUN:  phase_d[ch] = en_eff[ch] ? PH_RUN : PH_IDLE;
        default: phase_d[ch] = PH_IDLE;
      endcase
      cnt_d[ch]  = cnt_q[ch];
      pwm_d[ch]  = 1'b0;
      oe_n_d[ch] = !en_eff[ch];
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      hi = 2 * p;
      lo = 2 * p + 1;
      if (concat_q[p]) begin
        // high byte from the even channel, timing from the odd one
        c16    = {cnt_q[hi], cnt_q[lo]};
        per16  = {I_CH_CFG[hi].period, I_CH_CFG[lo].period};
        duty16 = {I_CH_CFG[hi].duty, I_CH_CFG[lo].duty};
        if (phase_d[lo] != PH_RUN) begin
          c16 = 16'h0000;
        end else if (phase_q[lo] == PH_RUN && tick[lo]) begin
          c16 = next_count(c16, per16); // first period not trimmed
        end
        {cnt_d[hi], cnt_d[lo]} = c16;
        pwm_d[lo] = (phase_d[lo] == PH_RUN) && wave_level(pol_q[lo], c16, duty16);
        pwm_d[hi] = 1'b0;
      end else begin
        for (int k = 0; k < 2; k++) begin
          lo     = 2 * p + k;
          c16    = {8'h00, cnt_q[lo]};
          per16  = {8'h00, I_CH_CFG[lo].period};
          duty16 = {8'h00, I_CH_CFG[lo].duty};
          if (phase_d[lo] != PH_RUN) begin
            c16 = 16'h0000;
          end else if (phase_q[lo] == PH_RUN && tick[lo]) begin
            c16 = next_count(c16, per16);
          end
          cnt_d[lo] = c16[7:0];
          // polarity read live, a change mid-period may glitch
          pwm_d[lo] = (phase_d[lo] == PH_RUN) && wave_level(pol_q[lo], c16, duty16);
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        phase_q[ch] <= PH_IDLE;
        cnt_q[ch]   <= 8'h00;
      end
      pwm_q  <= 6'h00;
      oe_n_q <= 6'h3F;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        phase_q[ch] <= phase_d[ch];
        cnt_q[ch]   <= cnt_d[ch];
      end
      pwm_q  <= pwm_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign O_PWM      = pwm_q;
  assign O_PWM_OE_N = oe_n_q;

endmodule

`default_nettype wire

// ### hw/pwm_ctl_pkg.sv
//==========================================================
`default_nettype none

package pwm_ctl_pkg;

  //==========================================================
  // sizes
  localparam int NUM_CH   = 6;
  localparam int NUM_PAIR = 3;

  //==========================================================
  // register indexes, byte address is index times four
  localparam logic [5:0] IDX_ENABLE   = 6'h00;
  localparam logic [5:0] IDX_POLARITY = 6'h01;
  localparam logic [5:0] IDX_CLKSEL   = 6'h02;
  localparam logic [5:0] IDX_PRESCALE = 6'h03;
  localparam logic [5:0] IDX_CONCAT   = 6'h05;
  localparam logic [5:0] IDX_SCALE_A  = 6'h08;
  localparam logic [5:0] IDX_SCALE_B  = 6'h09;

  //==========================================================
  // field positions
  localparam int PRE_A_LSB  = 0;
  localparam int PRE_B_LSB  = 4;
  localparam int CONCAT_LSB = 4;

  //==========================================================
  // reset values
  localparam logic [5:0] RST_ENABLE   = 6'h00;
  localparam logic [5:0] RST_POLARITY = 6'h00;
  localparam logic [5:0] RST_CLKSEL   = 6'h00;
  localparam logic [5:0] RST_PRESCALE = 6'h00;
  localparam logic [2:0] RST_CONCAT   = 3'h0;
  localparam logic [7:0] RST_SCALE    = 8'h00;

  // channels fed by clock B
  localparam logic [5:0] CLK_B_CH_MASK = 6'h0C;

  //==========================================================
  // types
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SYNC,
    PH_RUN
  } phase_e;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] duty;
  } ch_cfg_s;

endpackage

`default_nettype wire

// ### verif/pwm_channel_ctl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_ctl_bench;
  import pwm_ctl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x;} row_s;
  logic              I_CLK     = 1'b0;
  logic              I_RST     = 1'b1;
  logic              I_PSEL    = 1'b0;
  logic              I_PENABLE = 1'b0;
  logic              I_PWRITE  = 1'b0;
  logic [7:0]        I_PADDR   = 8'h00;
  logic [31:0]       I_PWDATA  = 32'h0000_0000;
  ch_cfg_s [5:0]     I_CH_CFG  = {6{16'h0402}};
  logic [31:0]       O_PRDATA;
  logic              O_PREADY;
  logic              O_PSLVERR;
  logic [5:0]        O_PWM;
  logic [5:0]        O_PWM_OE_N;
  logic              O_PRESCALE_RUN;
  int                n_mismatch = 0;
  int                compares   = 0;
  logic [31:0]       rd;
  logic              er;
  row_s              rows [7] = '{
    {8'h00, 32'hFFFF_FF15, 32'h0000_0015}, {8'h04, 32'h0000_003F, 32'h0000_003F},
    {8'h08, 32'h0000_002A, 32'h0000_002A}, {8'h0C, 32'h0000_00FF, 32'h0000_0077},
    {8'h14, 32'h0000_00FF, 32'h0000_0070}, {8'h20, 32'h0000_00A5, 32'h0000_00A5},
    {8'h24, 32'h0000_005A, 32'h0000_005A}};

  always #25 I_CLK = ~I_CLK;

  pwm_channel_ctl u_dut (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CH_CFG(I_CH_CFG), .O_PWM(O_PWM),
    .O_PWM_OE_N(O_PWM_OE_N), .O_PRESCALE_RUN(O_PRESCALE_RUN)
  );

  //==========================================================
  // tasks
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    @(posedge I_CLK);
    while (O_PREADY !== 1'b1) @(posedge I_CLK);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic do_reset;
    I_RST <= 1'b1;
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(negedge I_CLK);
  endtask

  // skips the first period, collects the second, step cycles per count
  task automatic wave(input int ch, input logic [3:0] x, input int step);
    logic [3:0] got;
    repeat (2) @(negedge I_CLK);
    chk(O_PWM_OE_N[ch] === 1'b0, "pin not on");
    repeat (4 * step) @(negedge I_CLK);
    for (int k = 3; k >= 0; k--) begin
      repeat (step) @(negedge I_CLK);
      got[k] = O_PWM[ch];
    end
    chk(got === x, "waveform");
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  //==========================================================
  // sequence
  initial begin
    do_reset;
    chk(O_PWM_OE_N === 6'h3F && O_PWM === 6'h00 && O_PRESCALE_RUN === 1'b0, "reset pins");
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(rd === 32'h0000_0000, "reset value");
    end
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd === rows[i].x && er === 1'b0, "readback");
    end
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rd === 32'h0000_0000 && er === 1'b1, "unmapped");
    apb(1'b0, 8'h01, 32'h0000_0000);
    chk(er === 1'b1, "misaligned");
    do_reset;
    chk(O_PRESCALE_RUN === 1'b0 && O_PWM_OE_N === 6'h3F, "second reset");
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd === 32'h0000_0000, "enable after reset");
    apb(1'b1, 8'h04, 32'h0000_0002);
    apb(1'b1, 8'h00, 32'h0000_0002);
    wave(1, 4'b1100, 1);
    chk(O_PRESCALE_RUN === 1'b1, "prescaler stopped");
    apb(1'b1, 8'h00, 32'h0000_0008);
    wave(3, 4'b0011, 1);
    chk(O_PWM_OE_N[1] === 1'b1, "ch1 still on");
    apb(1'b1, 8'h00, 32'h0000_0000);
    @(negedge I_CLK);
    chk(O_PRESCALE_RUN === 1'b0, "prescaler running");
    apb(1'b1, 8'h14, 32'h0000_0010);
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (3) @(negedge I_CLK);
    chk(O_PWM_OE_N === 6'h3F && O_PWM[0] === 1'b0, "high half on");
    apb(1'b1, 8'h00, 32'h0000_0003);
    repeat (2) @(negedge I_CLK);
    chk(O_PWM_OE_N === 6'h3D, "pair pins");
    repeat (3) @(negedge I_CLK);
    chk(O_PWM === 6'h02, "pair wave");
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0002);
    wave(1, 4'b1100, 2);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_000A);
    apb(1'b1, 8'h20, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0002);
    wave(1, 4'b1100, 2);
    apb(1'b1, 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0008);
    wave(3, 4'b0011, 2);
    conclude;
  end

  initial begin
    repeat (2000) @(posedge I_CLK);
    n_mismatch++;
    conclude;
  end
endmodule

`default_nettype wire

// ### verif/pwm_channel_ctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_channel_ctl_monitor (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [5:0]  O_PWM,
  input wire logic [5:0]  O_PWM_OE_N,
  input wire logic        O_PRESCALE_RUN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  wire logic acc_w = I_PSEL && I_PENABLE;

  //==========================================================
  // bus
  pready_high_a: assert property (O_PREADY)
    else $error("ready low");
  err_access_only_a: assert property (O_PSLVERR |-> acc_w)
    else $error("error outside access");
  misaligned_err_a: assert property (acc_w && I_PADDR[1:0] != 2'h0 |-> O_PSLVERR)
    else $error("misaligned accepted");
  err_read_zero_a: assert property (acc_w && !I_PWRITE && O_PSLVERR |-> ~|O_PRDATA)
    else $error("refused read not zero");
  upper_data_zero_a: assert property (~|O_PRDATA[31:8])
    else $error("upper read bits set");

  //==========================================================
  // channels
  idle_all_off_a: assert property (!O_PRESCALE_RUN && !$past(O_PRESCALE_RUN) |-> &O_PWM_OE_N)
    else $error("pin driven while idle");
  off_pin_low_a: assert property ((O_PWM & O_PWM_OE_N) == 6'h00)
    else $error("disabled pin high");
  odd_enable_a: assert property (acc_w && I_PWRITE && I_PADDR == 8'h00 |-> ##2
    {O_PWM_OE_N[5], O_PWM_OE_N[3], O_PWM_OE_N[1]} == ~$past({I_PWDATA[5], I_PWDATA[3], I_PWDATA[1]}, 2))
    else $error("enable not applied");
endmodule

bind pwm_channel_ctl pwm_channel_ctl_monitor u_mon (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PWM(O_PWM), .O_PWM_OE_N(O_PWM_OE_N),
  .O_PRESCALE_RUN(O_PRESCALE_RUN)
);

`default_nettype wire
